// ### rsd_cfg.svh
`ifndef RSD_CFG_SVH
`define RSD_CFG_SVH

// Master clock rate of this block (pclk), MHz
`define RSD_CLK_MHZ       250
`define RSD_N_IN          14
`define RSD_FW            16
`define RSD_NONE          4'hf

// Register byte offsets
`define RSD_A_CTRL        12'h000
`define RSD_A_STATUS      12'h004
`define RSD_A_VALID       12'h008
`define RSD_A_FREE_FREQ   12'h00c
`define RSD_A_TOL         12'h010
`define RSD_A_PHASE_ADJ   12'h014
`define RSD_A_HOLD_FREQ   12'h018
`define RSD_A_MEAS        12'h01c
`define RSD_A_SYS_FREQ    12'h020
`define RSD_A_PHASE_ERR   12'h024
// Per-input windows: base + 4*index, index selected by addr[5:2]
`define RSD_W_PERIOD      6'h01
`define RSD_W_ICFG        6'h02

// Reset values
`define RSD_RST_CTRL      16'h0001
`define RSD_RST_FREE_FREQ 16'h7a12
`define RSD_RST_TOL       16'h0010

// Status field positions
`define RSD_ST_HOLD_OK    2
`define RSD_ST_SYS_SEL    4
`define RSD_ST_AUX_SEL    8

`endif

// ### rsd_pkg.sv
package rsd_pkg;

	typedef enum logic [1:0] {
		RSD_FREE   = 2'b00,
		RSD_LOCKED = 2'b01,
		RSD_HOLD   = 2'b10
	} rsd_state_t;

	typedef enum logic [1:0] {
		RSD_AUX_INPUT = 2'b00,
		RSD_AUX_SYS   = 2'b01,
		RSD_AUX_FREQ  = 2'b10,
		RSD_AUX_PHASE = 2'b11
	} rsd_aux_mode_t;

	typedef struct packed {
		logic [3:0]    meas_b;
		logic [3:0]    meas_a;
		logic [2:0]    rsvd;
		rsd_aux_mode_t aux_mode;
		logic          aux_8k;
		logic          sys_8k;
		logic          revertive;
	} rsd_ctrl_t;

	typedef struct packed {
		logic [15:0] div;
		logic [3:0]  aux_prio;
		logic [3:0]  sys_prio;
	} rsd_icfg_t;

endpackage : rsd_pkg

// ### rsd_ctrl.sv
// Operation
// - System loop changes between free-run, locked, holdover entirely in hardware.
// - Free-run output derives only from the local oscillator clock and stored word.
// - A valid selected reference puts the system loop into locked, tracking it.
// - While locked, average the reference period and store it for holdover.
// - Failure of the locked reference sends the loop to holdover at once.
// - From holdover, relock to next best valid reference without output phase step.
// - Switching is revertive or nonrevertive under software control.
// - With no valid reference, stay in holdover using the stored average, or the free-run word until one is stored.
// - Phase build-out on switches plus software fine phase adjustment.
// - Both loops may lock at 8kHz to any input multiple of 8kHz.
// - Auxiliary loop may lock to the system loop output instead.
// - Auxiliary loop measures an input frequency or phase between two inputs.
// - All 14 inputs are watched continuously for activity and frequency.
// - Separate priority tables for system loop and auxiliary loop.
// - Highest priority valid input is picked and delivered automatically.
// - Chosen reference is divided to 8kHz when the loop asks for it.
// - All logic runs from the single master clock.
// - Two missing expected input cycles disqualify the input.
`timescale 1ns/1ps
`include "rsd_cfg.svh"
`default_nettype none

module rsd_ctrl #(
	parameter int N         = `RSD_N_IN,
	parameter int AVG_SHIFT = 8
) (
	// APB slave
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Reference clock pins
	input  wire logic [N-1:0]        ref_in,
	// Loop side
	output rsd_pkg::rsd_state_t      sys_state,
	output logic      [`RSD_FW-1:0]  sys_freq,
	output logic                     sys_tick,
	output logic                     sys_ref_pulse,
	output logic                     aux_ref_pulse,
	output logic                     hold_ok
);
	import rsd_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Registers
	rsd_ctrl_t         ctrl_q;
	rsd_icfg_t         icfg_q    [N];
	logic [15:0]       per_q     [N];
	logic [15:0]       free_q, tol_q, adj_q;
	logic [31:0]       prdata_q;
	logic              pready_q, pslverr_q;

	// Monitor state
	logic [N-1:0]      s1_q, s2_q, s3_q, edge_q, div_pulse_q, active_q, fok_q, valid_q;
	logic [15:0]       cnt_q     [N];
	logic [15:0]       mper_q    [N];
	logic [15:0]       dcnt_q    [N];
	logic [N*4-1:0]    sys_prio, aux_prio;

	// Loop state
	rsd_state_t        st_q;
	logic [3:0]        lock_q, aux_q, sys_pick, aux_pick, ph_ref_q;
	logic              sys_have, aux_have;
	logic [15:0]       freq_q, hold_q, ph_q, lc_q, pbo_q, perr_q, meas_q, mcnt_q;
	logic [15+AVG_SHIFT:0] acc_q;
	logic [AVG_SHIFT-1:0]  nacc_q;
	logic              hold_ok_q, tick_q, sys_rp_q, aux_rp_q;
	logic [N-1:0]      sys_src, aux_src;

	wire logic         wr_en = psel & penable & pwrite & pready_q;
	wire logic [3:0]   widx  = paddr[5:2];

	////////////////////////////////////////////////////////////////////////
	// APB access, zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= psel & ~penable;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			if (psel & ~penable) begin
				unique case (paddr)
					`RSD_A_CTRL:      prdata_q <= {16'h0000, ctrl_q};
					`RSD_A_STATUS:    prdata_q <= {18'h00000, sys_have, aux_have, aux_q, lock_q,
					                               1'b0, hold_ok_q, st_q};
					`RSD_A_VALID:     prdata_q <= {{(32-N){1'b0}}, valid_q};
					`RSD_A_FREE_FREQ: prdata_q <= {16'h0000, free_q};
					`RSD_A_TOL:       prdata_q <= {16'h0000, tol_q};
					`RSD_A_PHASE_ADJ: prdata_q <= {16'h0000, adj_q};
					`RSD_A_HOLD_FREQ: prdata_q <= {16'h0000, hold_q};
					`RSD_A_MEAS:      prdata_q <= {16'h0000, meas_q};
					`RSD_A_SYS_FREQ:  prdata_q <= {16'h0000, freq_q};
					`RSD_A_PHASE_ERR: prdata_q <= {16'h0000, perr_q};
					default: begin
						if (paddr[11:6] == `RSD_W_PERIOD && 32'(widx) < N)
							prdata_q <= {16'h0000, per_q[widx]};
						else if (paddr[11:6] == `RSD_W_ICFG && 32'(widx) < N)
							prdata_q <= {8'h00, icfg_q[widx]};
						else
							pslverr_q <= 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= rsd_ctrl_t'(`RSD_RST_CTRL);
			free_q <= `RSD_RST_FREE_FREQ;
			tol_q  <= `RSD_RST_TOL;
			adj_q  <= 16'h0000;
			for (int i = 0; i < N; i++) begin
				per_q[i]  <= 16'h0000;
				icfg_q[i] <= '0;
			end
		end else if (wr_en) begin
			if (paddr == `RSD_A_CTRL)           ctrl_q <= rsd_ctrl_t'(pwdata[15:0]);
			if (paddr == `RSD_A_FREE_FREQ)      free_q <= pwdata[15:0];
			if (paddr == `RSD_A_TOL)            tol_q  <= pwdata[15:0];
			if (paddr == `RSD_A_PHASE_ADJ)      adj_q  <= pwdata[15:0];
			if (paddr[11:6] == `RSD_W_PERIOD && 32'(widx) < N) per_q[widx]  <= pwdata[15:0];
			if (paddr[11:6] == `RSD_W_ICFG && 32'(widx) < N)   icfg_q[widx] <= rsd_icfg_t'(pwdata[23:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-input monitor and 8kHz divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= ref_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	for (genvar g = 0; g < N; g++) begin : g_mon
		wire logic        rise = s2_q[g] & ~s3_q[g];
		wire logic [15:0] dif  = (cnt_q[g] > per_q[g]) ? cnt_q[g] - per_q[g] : per_q[g] - cnt_q[g];
		assign sys_prio[g*4 +: 4] = icfg_q[g].sys_prio;
		assign aux_prio[g*4 +: 4] = icfg_q[g].aux_prio;
		assign sys_src[g] = ctrl_q.sys_8k ? div_pulse_q[g] : edge_q[g];
		assign aux_src[g] = ctrl_q.aux_8k ? div_pulse_q[g] : edge_q[g];
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_q[g]       <= 16'h0000;
				mper_q[g]      <= 16'h0000;
				dcnt_q[g]      <= 16'h0000;
				edge_q[g]      <= 1'b0;
				div_pulse_q[g] <= 1'b0;
				active_q[g]    <= 1'b0;
				fok_q[g]       <= 1'b0;
				valid_q[g]     <= 1'b0;
			end else begin
				edge_q[g]      <= rise;
				div_pulse_q[g] <= 1'b0;
				if (rise) begin
					cnt_q[g]    <= 16'h0001;
					mper_q[g]   <= cnt_q[g];
					active_q[g] <= per_q[g] != 16'h0000;
					fok_q[g]    <= per_q[g] != 16'h0000 && dif <= tol_q;
					if (dcnt_q[g] + 16'h0001 >= icfg_q[g].div) begin
						dcnt_q[g]      <= 16'h0000;
						div_pulse_q[g] <= 1'b1;
					end else begin
						dcnt_q[g] <= dcnt_q[g] + 16'h0001;
					end
				end else begin
					if (cnt_q[g] != 16'hffff)
						cnt_q[g] <= cnt_q[g] + 16'h0001;
					if ({1'b0, cnt_q[g]} > {per_q[g], 1'b0})
						active_q[g] <= 1'b0;
				end
				valid_q[g] <= active_q[g] & fok_q[g];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Priority selection; 1 is the highest priority, 0 excludes the input
	function automatic logic [4:0] rsd_pick(input logic [N*4-1:0] prio, input logic [N-1:0] ok,
	                                        input logic [3:0] cur, input logic keep);
		logic [4:0] best;
		logic [3:0] idx;
		logic [3:0] p;
		best = 5'h10;
		idx  = `RSD_NONE;
		for (int i = 0; i < N; i++) begin
			p = prio[i*4 +: 4];
			if (ok[i] && p != 4'h0 && ({1'b0, p} < best || ({1'b0, p} == best && 4'(i) == cur))) begin
				best = {1'b0, p};
				idx  = 4'(i);
			end
		end
		if (keep && cur != `RSD_NONE && ok[cur] && prio[cur*4 +: 4] != 4'h0)
			idx = cur;
		return {idx != `RSD_NONE, idx};
	endfunction : rsd_pick

	assign {sys_have, sys_pick} = rsd_pick(sys_prio, valid_q, lock_q,
	                                       ~ctrl_q.revertive && st_q == RSD_LOCKED);
	assign {aux_have, aux_pick} = rsd_pick(aux_prio, valid_q, aux_q, ~ctrl_q.revertive);

	////////////////////////////////////////////////////////////////////////
	// System loop state machine
	wire logic lock_ok = lock_q != `RSD_NONE && valid_q[lock_q];
	wire logic rp      = lock_q != `RSD_NONE && sys_src[lock_q];
	// First edge after a lock or switch only opens a period; it measures nothing
	wire logic samp    = rp && ph_ref_q == lock_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q   <= RSD_FREE;
			lock_q <= `RSD_NONE;
			pbo_q  <= 16'h0000;
		end else begin
			unique case (st_q)
				RSD_FREE: begin
					if (sys_have) begin
						st_q   <= RSD_LOCKED;
						lock_q <= sys_pick;
						pbo_q  <= lc_q;
					end
				end
				RSD_LOCKED: begin
					if (!lock_ok) begin
						st_q <= RSD_HOLD;
					end else if (sys_have && sys_pick != lock_q) begin
						lock_q <= sys_pick;
						pbo_q  <= lc_q;
					end
				end
				RSD_HOLD: begin
					if (sys_have) begin
						st_q   <= RSD_LOCKED;
						lock_q <= sys_pick;
						pbo_q  <= lc_q;
					end
				end
				default: st_q <= RSD_FREE;
			endcase
		end
	end

	// Frequency word, local output tick and phase error; all on pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_q   <= `RSD_RST_FREE_FREQ;
			ph_q     <= 16'h0000;
			lc_q     <= 16'h0000;
			perr_q   <= 16'h0000;
			tick_q   <= 1'b0;
			sys_rp_q <= 1'b0;
			ph_ref_q <= `RSD_NONE;
		end else begin
			sys_rp_q <= rp;
			ph_ref_q <= (st_q != RSD_LOCKED) ? `RSD_NONE : (rp ? lock_q : ph_ref_q);
			ph_q     <= rp ? 16'h0000 : ph_q + 16'h0001;
			tick_q   <= lc_q + 16'h0001 >= freq_q;
			lc_q     <= (lc_q + 16'h0001 >= freq_q) ? 16'h0000 : lc_q + 16'h0001;
			if (st_q == RSD_LOCKED && samp) begin
				freq_q <= ph_q + 16'h0001;
				perr_q <= lc_q - pbo_q + adj_q;
			end else if (st_q == RSD_FREE) begin
				freq_q <= free_q;
			end else if (st_q == RSD_HOLD) begin
				freq_q <= hold_ok_q ? hold_q : free_q;
			end
		end
	end

	// Holdover averaging over 2**AVG_SHIFT reference periods
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q     <= '0;
			nacc_q    <= '0;
			hold_q    <= 16'h0000;
			hold_ok_q <= 1'b0;
		end else if (st_q == RSD_LOCKED && samp && lock_ok) begin
			if (&nacc_q) begin
				hold_q    <= 16'((acc_q + (16+AVG_SHIFT)'(ph_q + 16'h0001)) >> AVG_SHIFT);
				hold_ok_q <= 1'b1;
				acc_q     <= '0;
			end else begin
				acc_q <= acc_q + (16+AVG_SHIFT)'(ph_q + 16'h0001);
			end
			nacc_q <= nacc_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Auxiliary loop reference and measurement
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_q    <= `RSD_NONE;
			aux_rp_q <= 1'b0;
			meas_q   <= 16'h0000;
			mcnt_q   <= 16'h0000;
		end else begin
			aux_q    <= aux_have ? aux_pick : `RSD_NONE;
			aux_rp_q <= 1'b0;
			mcnt_q   <= (mcnt_q != 16'hffff) ? mcnt_q + 16'h0001 : mcnt_q;
			unique case (ctrl_q.aux_mode)
				RSD_AUX_INPUT: aux_rp_q <= aux_q != `RSD_NONE && aux_src[aux_q];
				RSD_AUX_SYS:   aux_rp_q <= tick_q;
				RSD_AUX_FREQ:  meas_q   <= mper_q[ctrl_q.meas_a];
				RSD_AUX_PHASE: begin
					if (edge_q[ctrl_q.meas_a])
						mcnt_q <= 16'h0000;
					else if (edge_q[ctrl_q.meas_b])
						meas_q <= mcnt_q;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign prdata        = prdata_q;
	assign pready        = pready_q;
	assign pslverr       = pslverr_q;
	assign sys_state     = st_q;
	assign sys_freq      = freq_q;
	assign sys_tick      = tick_q;
	assign sys_ref_pulse = sys_rp_q;
	assign aux_ref_pulse = aux_rp_q;
	assign hold_ok       = hold_ok_q;

endmodule : rsd_ctrl

`default_nettype wire

// ### rsd_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rsd_chk #(
	parameter int GAP_MAX = 120
) (
	// Bus
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	// Loop
	input wire rsd_pkg::rsd_state_t sys_state,
	input wire logic                hold_ok,
	input wire logic                sys_ref_pulse
);
	import rsd_pkg::*;
	logic [9:0] gap_q;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// Cycles since last reference edge while locked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q <= '0;
		end else if (sys_state != RSD_LOCKED || sys_ref_pulse) begin
			gap_q <= '0;
		end else begin
			gap_q <= gap_q + 10'h001;
		end
	end
	////////////////////////////////////////////////////////////////
	property p_state_legal; sys_state != 2'b11; endproperty
	a_state_legal: assert property (p_state_legal) else $error("illegal loop state");
	property p_free_no_hold; sys_state == RSD_FREE |=> sys_state != RSD_HOLD; endproperty
	a_free_no_hold: assert property (p_free_no_hold) else $error("free-run jumped to holdover");
	property p_no_refree; sys_state != RSD_FREE |=> sys_state != RSD_FREE; endproperty
	a_no_refree: assert property (p_no_refree) else $error("loop fell back to free-run");
	property p_hold_src; $rose(hold_ok) |-> $past(sys_state) == RSD_LOCKED; endproperty
	a_hold_src: assert property (p_hold_src) else $error("average acquired outside lock");
	property p_hold_keep; hold_ok |=> hold_ok; endproperty
	a_hold_keep: assert property (p_hold_keep) else $error("stored average lost");
	property p_gap; gap_q <= 10'(GAP_MAX); endproperty
	a_gap: assert property (p_gap) else $error("locked on a silent reference");
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_ready_src; pready |-> $past(psel && !penable); endproperty
	a_ready_src: assert property (p_ready_src) else $error("ready without setup");
	property p_idle_rd; !pready |-> prdata == 32'h0; endproperty
	a_idle_rd: assert property (p_idle_rd) else $error("read data outside access");
endmodule : rsd_chk
bind rsd_ctrl rsd_chk #(.GAP_MAX(120)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .sys_state(sys_state), .hold_ok(hold_ok), .sys_ref_pulse(sys_ref_pulse));
`default_nettype wire

// ### rsd_ref_src.sv
`timescale 1ns/1ps
`default_nettype none
module rsd_ref_src #(
	parameter int N    = 14,
	parameter int BASE = 24
) (
	// Control
	input  wire logic         pclk,
	input  wire logic [N-1:0] en,
	input  wire logic [N-1:0] off,
	// Reference pins
	output logic      [N-1:0] ref_in
);
	logic [7:0] cnt_q [N];
	// Stopped source sits low like a pulled line card; off adds 4 cycles
	for (genvar i = 0; i < N; i++) begin : g_src
		always_ff @(posedge pclk) begin
			if (!en[i] || cnt_q[i] >= 8'(BASE - 1) + (off[i] ? 8'h04 : 8'h00)) begin
				cnt_q[i] <= 8'h00;
			end else begin
				cnt_q[i] <= cnt_q[i] + 8'h01;
			end
			ref_in[i] <= en[i] && (cnt_q[i] < 8'(BASE / 2));
		end
	end
endmodule : rsd_ref_src
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`include "rsd_cfg.svh"
`default_nettype none
module tb_top;
	import rsd_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [13:0] ref_in, en, off;
	rsd_state_t  sys_state;
	logic [15:0] sys_freq;
	logic        sys_tick, sys_ref_pulse, aux_ref_pulse, hold_ok, saw_hold;
	int          err_count, num_checks, seed, cnt;
	logic [3:0]  sp [4] = '{4'h1, 4'h3, 4'h2, 4'h2};
	logic [3:0]  ap [4] = '{4'h2, 4'h1, 4'h3, 4'h3};
	rsd_ctrl #(.N(14), .AVG_SHIFT(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ref_in(ref_in), .sys_state(sys_state), .sys_freq(sys_freq), .sys_tick(sys_tick),
		.sys_ref_pulse(sys_ref_pulse), .aux_ref_pulse(aux_ref_pulse), .hold_ok(hold_ok));
	rsd_ref_src #(.N(14), .BASE(24)) src_u (.pclk(pclk), .en(en), .off(off), .ref_in(ref_in));
	////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) if (sys_state === RSD_HOLD) saw_hold <= 1'b1;
	function automatic logic [31:0] st(input logic [1:0] s, input logic [3:0] i);
		return {24'h0, i, 2'b00, s};
	endfunction : st
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Request held until ready seen; idle cycle after avoids double drive
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat & m, exp);
	endtask : rdc
	////////////////////////////////////////////////////////////////
	initial begin
		rsd_ctrl_t c;
		seed = 69947; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0; en = 14'h0000; off = 14'h0000; saw_hold = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(`RSD_A_CTRL, 32'hffffffff, 32'h1);
		rdc(`RSD_A_STATUS, 32'h7, 32'h0);
		rdc(`RSD_A_FREE_FREQ, 32'hffffffff, 32'h7a12);
		rdc(`RSD_A_TOL, 32'hffffffff, 32'h10);
		apb(1'b0, 12'h07c, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		apb(1'b1, 12'h07c, 32'h5);
		chk({31'h0, rerr}, 32'h1);
		apb(1'b1, `RSD_A_CTRL, 32'h0);
		apb(1'b1, `RSD_A_TOL, 32'h2);
		rdc(`RSD_A_TOL, 32'hffff, 32'h2);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h040 + 12'(4 * i), 32'd24);
			apb(1'b1, 12'h080 + 12'(4 * i), {24'h0, ap[i], sp[i]});
		end
		// Input 0 runs 4 cycles slow, beyond tolerance
		off <= 14'h0001;
		en <= {10'($random(seed)), 4'hf};
		for (int n = 0; n < 2000 && sys_state !== RSD_LOCKED; n++) @(posedge pclk);
		rdc(`RSD_A_STATUS, 32'hff3, 32'h100 | st(2'b01, 4'h2));
		rdc(`RSD_A_VALID, 32'h3fff, 32'he);
		for (int n = 0; n < 2000 && hold_ok !== 1'b1; n++) @(posedge pclk);
		chk(32'(hold_ok), 32'h1);
		rdc(`RSD_A_HOLD_FREQ, 32'hffff, 32'd24);
		chk(32'(sys_freq), 32'd24);
		en[2] <= 1'b0;
		repeat (100) @(posedge pclk);
		for (int n = 0; n < 2000 && sys_state !== RSD_LOCKED; n++) @(posedge pclk);
		chk(32'(saw_hold), 32'h1);
		rdc(`RSD_A_STATUS, 32'hf3, st(2'b01, 4'h3));
		off <= 14'h0000;
		repeat (150) @(posedge pclk);
		rdc(`RSD_A_VALID, 32'hf, 32'hb);
		rdc(`RSD_A_STATUS, 32'hf3, st(2'b01, 4'h3));
		apb(1'b1, `RSD_A_CTRL, 32'h1);
		repeat (10) @(posedge pclk);
		rdc(`RSD_A_STATUS, 32'hf3, st(2'b01, 4'h0));
		// Input 1 divided by two, so its aux pulses come every 48 cycles
		apb(1'b1, 12'h084, {8'h00, 16'h0002, ap[1], sp[1]});
		for (int m = 0; m < 4; m++) begin
			c = '0;
			c.revertive = 1'b1;
			c.aux_mode = rsd_aux_mode_t'(m);
			c.aux_8k = (m == 0);
			c.meas_a = 4'($random(seed)) & 4'h3;
			c.meas_b = 4'($random(seed));
			apb(1'b1, `RSD_A_CTRL, 32'(c));
			rdc(`RSD_A_CTRL, 32'hffff, 32'(c));
			cnt = 0;
			repeat (200) begin
				@(posedge pclk);
				cnt += (aux_ref_pulse === 1'b1);
			end
			chk(32'(cnt != 0), 32'(m < 2));
			if (m == 0) chk(32'(cnt >= 4 && cnt <= 5), 32'h1);
			if (m == 2) rdc(`RSD_A_MEAS, 32'hffff, 32'd24);
		end
		en <= 14'h0000;
		repeat (300) @(posedge pclk);
		rdc(`RSD_A_STATUS, 32'h3, 32'h2);
		chk(32'(sys_freq), 32'd24);
		rdc(`RSD_A_VALID, 32'h3fff, 32'h0);
		summarize();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		summarize();
	end
endmodule : tb_top
`default_nettype wire
